/* rtl/ptd_pkg.sv */
// Constants and types for the target decode and power state block.
package ptd_pkg;
  typedef enum logic [1:0] {
    PTD_D0 = 2'h0,
    PTD_D3 = 2'h3
  } ptd_pwr_e;

  localparam logic [3:0] PTD_IO_RD = 4'h2;
  localparam logic [3:0] PTD_IO_WR = 4'h3;
  localparam logic [3:0] PTD_MEM_RD = 4'h6;
  localparam logic [3:0] PTD_MEM_WR = 4'h7;
  localparam logic [3:0] PTD_CFG_RD = 4'hA;
  localparam logic [3:0] PTD_CFG_WR = 4'hB;
  localparam logic [3:0] PTD_MEM_RDM = 4'hC;
  localparam logic [3:0] PTD_MEM_RDL = 4'hE;
  localparam logic [3:0] PTD_MEM_WRI = 4'hF;

  localparam logic [7:0] PTD_OFF_CMD = 8'h04;
  localparam logic [7:0] PTD_OFF_BAR0 = 8'h10;
  localparam logic [7:0] PTD_OFF_BAR1 = 8'h14;
  localparam logic [7:0] PTD_OFF_PM = 8'h44;
  localparam int PTD_OP_BIT = 7;
  localparam int PTD_CMD_IO_BIT = 0;
  localparam int PTD_CMD_MEM_BIT = 1;

  localparam logic [15:0] PTD_CMD_RST = 16'h0000;
  localparam logic [23:0] PTD_BAR_RST = 24'h000000;
  localparam logic [7:0] PTD_BAR0_LOW = 8'h01;
  localparam logic [7:0] PTD_BAR1_LOW = 8'h00;
  localparam logic [1:0] PTD_PM_RST = 2'h0;
endpackage : ptd_pkg

/* rtl/ptd_target.sv */
// Target address decode, configuration registers and power state control.
// Operation
// - Two-bit power field at 44h, 00=D0, 11=D3.
// - Function comes up in D0 after reset.
// - D3 gates SCSI clock and doubler PLL.
// - D3 holds soft reset asserted continuously.
// - D3 clears the PCI command register.
// - Writing D0 code returns from D3.
// - Configuration cycles need IDSEL asserted.
// - Low eight bits select configuration byte.
// - Configuration claimed only when AD10-8 zero.
// - Upper 128 config bytes alias operating registers.
// - Operating registers in both window halves.
// - Upper 24 bits match base, claim.
// - BAR1 places memory window, BAR0 I/O.
// - Command and byte enables steer access.
`timescale 1ns/1ps
module ptd_target (
  input wire logic clk,
  input wire logic reset,
  input wire logic addr_phase,
  input wire logic [31:0] ad_addr,
  input wire logic [3:0] bus_cmd,
  input wire logic idsel,
  input wire logic data_phase,
  input wire logic [3:0] be_n,
  input wire logic [31:0] wdata,
  input wire logic [31:0] op_rdata,
  output logic claim_r,
  output logic [31:0] rdata_r,
  output logic rvalid_r,
  output logic op_req_r,
  output logic op_wr_r,
  output logic [6:0] op_addr_r,
  output logic [3:0] op_be_r,
  output logic [31:0] op_wdata_r,
  output logic [15:0] cmd_reg_r,
  output ptd_pkg::ptd_pwr_e pwr_state_r,
  output logic scsi_clk_en_r,
  output logic pll_en_r,
  output logic soft_reset_r
);
  import ptd_pkg::*;

  logic sp_cfg_r;
  logic wr_r;
  logic [7:0] off_r;
  logic acc_r;
  logic cl_r;
  logic awr_r;
  logic [5:0] dw_r;
  logic [3:0] be_r;
  logic [31:0] wd_r;
  logic [23:0] bar0_r;
  logic [23:0] bar1_r;
  logic [1:0] pm_code_r;

  // Address phase command decode; unsupported memory reads and writes fold onto the
  // plain ones.
  wire is_io = (bus_cmd == PTD_IO_RD) || (bus_cmd == PTD_IO_WR);
  wire is_mem = (bus_cmd == PTD_MEM_RD) || (bus_cmd == PTD_MEM_WR) ||
    (bus_cmd == PTD_MEM_RDM) || (bus_cmd == PTD_MEM_RDL) || (bus_cmd == PTD_MEM_WRI);
  wire is_cfg = (bus_cmd == PTD_CFG_RD) || (bus_cmd == PTD_CFG_WR);
  wire is_wr = (bus_cmd == PTD_IO_WR) || (bus_cmd == PTD_MEM_WR) ||
    (bus_cmd == PTD_MEM_WRI) || (bus_cmd == PTD_CFG_WR);

  wire cfg_hit = is_cfg && idsel && (ad_addr[10:8] == 3'h0);
  wire mem_hit = is_mem && cmd_reg_r[PTD_CMD_MEM_BIT] &&
    (ad_addr[31:8] == bar1_r);
  wire io_hit = is_io && cmd_reg_r[PTD_CMD_IO_BIT] &&
    (ad_addr[31:8] == bar0_r);
  wire any_hit = cfg_hit || mem_hit || io_hit;

  wire claim_nxt = addr_phase ? any_hit : (data_phase ? 1'b0 : claim_r);
  wire go = claim_r && data_phase;
  // Memory and I/O always reach the operating registers, whichever half is hit.
  wire tgt_op = !sp_cfg_r || off_r[PTD_OP_BIT];

  always_ff @(posedge clk) begin
    if (reset) begin
      claim_r <= 1'b0;
      sp_cfg_r <= 1'b0;
      wr_r <= 1'b0;
      off_r <= 8'h00;
    end else begin
      claim_r <= claim_nxt;
      if (addr_phase) begin
        sp_cfg_r <= cfg_hit;
        wr_r <= is_wr;
        off_r <= ad_addr[7:0];
      end
    end
  end

  // Data phase: the operating register strobe leaves one edge after the data phase.
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_r <= 1'b0;
      cl_r <= 1'b0;
      awr_r <= 1'b0;
      dw_r <= 6'h00;
      be_r <= 4'hF;
      wd_r <= 32'h0;
      op_req_r <= 1'b0;
      op_wr_r <= 1'b0;
      op_addr_r <= 7'h00;
      op_be_r <= 4'h0;
      op_wdata_r <= 32'h0;
    end else begin
      acc_r <= go;
      cl_r <= go && !tgt_op;
      op_req_r <= go && tgt_op;
      if (go) begin
        awr_r <= wr_r;
        dw_r <= off_r[7:2];
        be_r <= be_n;
        wd_r <= wdata;
        op_wr_r <= wr_r;
        op_addr_r <= {off_r[6:2], 2'h0};
        op_be_r <= ~be_n;
        op_wdata_r <= wdata;
      end
    end
  end

  // Byte lane write strobes for the lower configuration half.
  logic [3:0] lw;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lw[g] = cl_r && awr_r && !be_r[g];
    end
  endgenerate

  wire wcmd = (dw_r == PTD_OFF_CMD[7:2]);
  wire wbar0 = (dw_r == PTD_OFF_BAR0[7:2]);
  wire wbar1 = (dw_r == PTD_OFF_BAR1[7:2]);
  wire wpm = (dw_r == PTD_OFF_PM[7:2]);
  wire in_d3 = (pwr_state_r == PTD_D3);

  logic [23:0] bar0_nxt;
  logic [23:0] bar1_nxt;
  generate
    for (g = 1; g < 4; g++) begin : g_bar
      assign bar0_nxt[8*g-1 -: 8] = (lw[g] && wbar0) ? wd_r[8*g+7 -: 8] : bar0_r[8*g-1 -: 8];
      assign bar1_nxt[8*g-1 -: 8] = (lw[g] && wbar1) ? wd_r[8*g+7 -: 8] : bar1_r[8*g-1 -: 8];
    end
  endgenerate

  // While in D3 the command register is forced clear, so writes there are lost.
  wire [15:0] cmd_nxt = in_d3 ? PTD_CMD_RST : {
    (lw[1] && wcmd) ? wd_r[15:8] : cmd_reg_r[15:8],
    (lw[0] && wcmd) ? wd_r[7:0] : cmd_reg_r[7:0]};

  wire pm_we = lw[0] && wpm;
  wire [1:0] pm_wv = wd_r[1:0];
  wire pm_legal = (pm_wv == PTD_D0) || (pm_wv == PTD_D3);
  wire [1:0] pm_code_nxt = pm_we ? pm_wv : pm_code_r;
  wire ptd_pwr_e pwr_nxt = (pm_we && pm_legal) ?
    ptd_pwr_e'(pm_wv) : pwr_state_r;
  wire d3_nxt = (pwr_nxt == PTD_D3);

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_reg_r <= PTD_CMD_RST;
      bar0_r <= PTD_BAR_RST;
      bar1_r <= PTD_BAR_RST;
      pm_code_r <= PTD_PM_RST;
      pwr_state_r <= PTD_D0;
      scsi_clk_en_r <= 1'b1;
      pll_en_r <= 1'b1;
      soft_reset_r <= 1'b0;
    end else begin
      cmd_reg_r <= cmd_nxt;
      bar0_r <= bar0_nxt;
      bar1_r <= bar1_nxt;
      pm_code_r <= pm_code_nxt;
      pwr_state_r <= pwr_nxt;
      scsi_clk_en_r <= !d3_nxt;
      pll_en_r <= !d3_nxt;
      soft_reset_r <= d3_nxt;
    end
  end

  // Read data for the lower configuration half; unimplemented locations read zero.
  wire [31:0] cfg_rd =
    wcmd ? {16'h0000, cmd_reg_r} :
    wbar0 ? {bar0_r, PTD_BAR0_LOW} :
    wbar1 ? {bar1_r, PTD_BAR1_LOW} :
    wpm ? {30'h0, pm_code_r} : 32'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 32'h0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= acc_r && !awr_r;
      if (acc_r && !awr_r) begin
        rdata_r <= cl_r ? cfg_rd : op_rdata;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_pwr_legal_code: assert property (pwr_state_r inside {PTD_D0, PTD_D3})
    else $error("power state holds a reserved code");
  a_reset_full_pwr: assert property (disable iff (1'b0)
    reset |=> pwr_state_r == PTD_D0 && !soft_reset_r)
    else $error("not in D0 after reset");
  a_d3_clk_off: assert property (in_d3 |-> !scsi_clk_en_r && !pll_en_r)
    else $error("clocks running in D3");
  a_d3_soft_reset: assert property (in_d3 |-> soft_reset_r)
    else $error("soft reset released in D3");
  a_d3_cmd_clear: assert property (in_d3 |=> cmd_reg_r == PTD_CMD_RST)
    else $error("command register not cleared in D3");
  a_wake_to_d0: assert property (pm_we && pm_wv == PTD_D0 |=>
    pwr_state_r == PTD_D0 ##0 scsi_clk_en_r && !soft_reset_r)
    else $error("no return to D0");
  a_cfg_no_idsel: assert property (addr_phase && is_cfg && !idsel |=> !claim_r)
    else $error("config cycle claimed without IDSEL");
  a_cfg_func_bits: assert property (addr_phase && is_cfg && ad_addr[10:8] != 3'h0
    |=> !claim_r)
    else $error("config cycle claimed with nonzero function");
  a_mem_base_hit: assert property (addr_phase && is_mem && cmd_reg_r[PTD_CMD_MEM_BIT]
    |=> claim_r == ($past(ad_addr[31:8]) == $past(bar1_r)))
    else $error("memory decode mismatch");
  a_op_alias_req: assert property (go && tgt_op |=>
    op_req_r && op_addr_r[1:0] == 2'h0 ##1 !op_req_r)
    else $error("operating register strobe missing");
  a_read_answer: assert property (go && !wr_r |=> !rvalid_r ##1 rvalid_r)
    else $error("read answer not two edges after data phase");
  a_resv_ignored: assert property (pm_we && !pm_legal |=>
    $stable(pwr_state_r) && pm_code_r == $past(pm_wv))
    else $error("reserved power code changed state");

  c_enter_d3: cover property (pm_we && pm_wv == PTD_D3 ##1 in_d3);
  c_wake_d0: cover property (in_d3 ##1 pm_we && pm_wv == PTD_D0);
  c_op_read: cover property (op_req_r && !op_wr_r ##1 rvalid_r);
  c_cfg_write: cover property (lw[0] && wbar1);
  c_cfg_upper: cover property (go && sp_cfg_r && off_r[PTD_OP_BIT]);

  // Decode and claim checks.
  a_claim_release: assert property (claim_r && data_phase && !addr_phase
    |=> !claim_r)
    else $error("claim held past the data phase");
  a_io_base_hit: assert property (addr_phase && is_io && cmd_reg_r[PTD_CMD_IO_BIT]
    |=> claim_r == ($past(ad_addr[31:8]) == $past(bar0_r)))
    else $error("io decode mismatch");
  a_cfg_hit_claim: assert property (addr_phase && cfg_hit |=> claim_r)
    else $error("selected config cycle not claimed");
  a_mem_disabled: assert property (addr_phase && is_mem && !cmd_reg_r[PTD_CMD_MEM_BIT]
    |=> !claim_r)
    else $error("memory cycle claimed while disabled");
  a_bad_cmd_ignored: assert property (addr_phase && !(is_cfg || is_mem || is_io)
    |=> !claim_r)
    else $error("unsupported command claimed");
  a_off_capture: assert property (addr_phase |=> off_r == $past(ad_addr[7:0]))
    else $error("register offset not captured");

  // Data phase checks.
  a_op_lanes: assert property (go |=> op_be_r == ~$past(be_n) &&
    op_wr_r == $past(wr_r))
    else $error("byte lanes or direction wrong");
  a_op_wdata: assert property (go |=> op_wdata_r == $past(wdata))
    else $error("write data not passed on");
  a_op_addr_align: assert property (op_req_r |-> op_addr_r[1:0] == 2'h0)
    else $error("operating offset not dword aligned");
  a_cfg_upper_op: assert property (go && sp_cfg_r && off_r[PTD_OP_BIT]
    |=> op_req_r)
    else $error("upper config half missed operating registers");
  a_cfg_lower_loc: assert property (go && sp_cfg_r && !off_r[PTD_OP_BIT]
    |=> !op_req_r)
    else $error("lower config half reached operating registers");
  a_write_no_ans: assert property (go && wr_r |-> ##2 !rvalid_r)
    else $error("write produced a read answer");
  a_bar_write: assert property (lw[1] && wbar1 |=> bar1_r[7:0] == $past(wd_r[15:8]))
    else $error("memory base byte not written");
  a_cmd_write: assert property (lw[0] && wcmd && !in_d3
    |=> cmd_reg_r[7:0] == $past(wd_r[7:0]))
    else $error("command byte not written");

  // Power state checks.
  a_d0_clk_on: assert property (!in_d3 |-> scsi_clk_en_r && pll_en_r &&
    !soft_reset_r)
    else $error("D0 outputs wrong");
  a_pm_readback: assert property (pm_we |=> pm_code_r == $past(pm_wv))
    else $error("power code not stored");
  a_d3_pwr_hold: assert property (in_d3 && !(pm_we && pm_wv == PTD_D0)
    |=> in_d3)
    else $error("D3 left without a D0 write");
  a_enter_d3: assert property (pm_we && pm_wv == PTD_D3 |=> in_d3 &&
    soft_reset_r)
    else $error("D3 write not taken");
endmodule : ptd_target

/* test/ptd_op_model.sv */
// Behavioural operating register file that answers the op strobe.
`timescale 1ns/1ps
module ptd_op_model (
  input wire logic clk,
  input wire logic op_req_r,
  input wire logic op_wr_r,
  input wire logic [6:0] op_addr_r,
  input wire logic [3:0] op_be_r,
  input wire logic [31:0] op_wdata_r,
  output logic [31:0] op_rdata
);
  logic [31:0] regs_r [32];
  initial for (int i = 0; i < 32; i++) regs_r[i] = 32'h0;
  // Outside a strobe the lines carry the inverse, so a stale capture cannot match.
  assign op_rdata = op_req_r ? regs_r[op_addr_r[6:2]] : ~regs_r[op_addr_r[6:2]];
  always @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (op_req_r && op_wr_r && op_be_r[b]) begin
        regs_r[op_addr_r[6:2]][8*b +: 8] <= op_wdata_r[8*b +: 8];
      end
    end
  end
endmodule : ptd_op_model

/* test/tb_top.sv */
// Self-checking bench for the target decode and power state block.
`timescale 1ns/1ps
module tb_top;
  import ptd_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic addr_phase = 1'b0, idsel = 1'b0, data_phase = 1'b0;
  logic [31:0] ad_addr = 32'h0, wdata = 32'h0, op_rdata, rdata_r, op_wdata_r;
  logic [3:0] bus_cmd = 4'h0, be_n = 4'hF, op_be_r;
  logic claim_r, rvalid_r, op_req_r, op_wr_r, scsi_clk_en_r, pll_en_r, soft_reset_r;
  logic [6:0] op_addr_r;
  logic [15:0] cmd_reg_r;
  ptd_pwr_e pwr_state_r;
  int errors = 0;
  int checks_done = 0;
  logic got_claim;
  logic [31:0] got_data;
  wire [4:0] pwr_view = {pwr_state_r, scsi_clk_en_r, pll_en_r, soft_reset_r};
  always #2 clk = ~clk;
  ptd_target i_dut (.clk, .reset, .addr_phase, .ad_addr, .bus_cmd, .idsel, .data_phase,
    .be_n, .wdata, .op_rdata, .claim_r, .rdata_r, .rvalid_r, .op_req_r, .op_wr_r,
    .op_addr_r, .op_be_r, .op_wdata_r, .cmd_reg_r, .pwr_state_r, .scsi_clk_en_r,
    .pll_en_r, .soft_reset_r);
  ptd_op_model i_ops (.clk, .op_req_r, .op_wr_r, .op_addr_r, .op_be_r, .op_wdata_r,
    .op_rdata);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
    input logic [3:0] ben, input logic [31:0] data);
    @(negedge clk);
    addr_phase = 1'b1;
    bus_cmd = cmd;
    ad_addr = addr;
    idsel = sel;
    @(negedge clk);
    addr_phase = 1'b0;
    ad_addr = ~addr;
    idsel = 1'b0;
    got_claim = claim_r;
    if (got_claim === 1'b1) begin
      data_phase = 1'b1;
      be_n = ben;
      wdata = data;
      @(negedge clk);
      data_phase = 1'b0;
      wdata = ~data;
      @(negedge clk);
      if (cmd[0] == 1'b0) chk(32'(rvalid_r), 32'h1, "read answer");
      got_data = rdata_r;
    end
  endtask : xfer
  task automatic t_reset();
    chk(32'(pwr_view), 32'h06, "reset power");
    chk(32'(cmd_reg_r), 32'h0, "reset command");
  endtask : t_reset
  task automatic t_config();
    xfer(PTD_CFG_WR, 32'h4, 1'b0, 4'hC, 32'h3);
    chk(32'(got_claim), 32'h0, "no idsel");
    xfer(PTD_CFG_WR, 32'h104, 1'b1, 4'hC, 32'h3);
    chk(32'(got_claim), 32'h0, "function bits");
    xfer(PTD_CFG_WR, 32'h4, 1'b1, 4'hC, 32'h3);
    chk(32'(cmd_reg_r), 32'h3, "command");
    xfer(PTD_CFG_WR, 32'h14, 1'b1, 4'h0, 32'h123456FF);
    xfer(PTD_CFG_RD, 32'h14, 1'b1, 4'h0, 32'h0);
    chk(got_data, 32'h12345600, "memory base");
    xfer(PTD_CFG_WR, 32'h10, 1'b1, 4'h0, 32'hABCDEF00);
    xfer(PTD_CFG_RD, 32'h10, 1'b1, 4'h0, 32'h0);
    chk(got_data, 32'hABCDEF01, "io base");
  endtask : t_config
  task automatic t_window();
    xfer(PTD_MEM_WR, 32'h12345608, 1'b0, 4'h0, 32'hCAFEF00D);
    chk({25'h0, op_addr_r}, 32'h8, "offset");
    chk({27'h0, op_wr_r, op_be_r}, 32'h1F, "write lanes");
    xfer(PTD_MEM_RD, 32'h12345688, 1'b0, 4'h0, 32'h0);
    chk(got_data, 32'hCAFEF00D, "upper half");
    xfer(PTD_IO_WR, 32'hABCDEF0B, 1'b0, 4'hE, 32'h000000AA);
    xfer(PTD_IO_RD, 32'hABCDEF08, 1'b0, 4'h0, 32'h0);
    chk(got_data, 32'hCAFEF0AA, "io byte");
    xfer(PTD_CFG_RD, 32'h88, 1'b1, 4'h0, 32'h0);
    chk(got_data, 32'hCAFEF0AA, "config alias");
    xfer(PTD_MEM_RDM, 32'h12345608, 1'b0, 4'h0, 32'h0);
    chk(got_data, 32'hCAFEF0AA, "read multiple");
    xfer(PTD_MEM_RD, 32'h12345708, 1'b0, 4'h0, 32'h0);
    chk(32'(got_claim), 32'h0, "base miss");
    xfer(4'h4, 32'h12345608, 1'b0, 4'h0, 32'h0);
    chk(32'(got_claim), 32'h0, "reserved command");
  endtask : t_window
  task automatic t_power();
    xfer(PTD_CFG_WR, 32'(PTD_OFF_PM), 1'b1, 4'hE, 32'h3);
    chk(32'(pwr_view), 32'h19, "enter d3");
    @(negedge clk);
    chk(32'(cmd_reg_r), 32'h0, "command cleared");
    xfer(PTD_MEM_RD, 32'h12345608, 1'b0, 4'h0, 32'h0);
    chk(32'(got_claim), 32'h0, "memory off");
    xfer(PTD_CFG_WR, 32'h4, 1'b1, 4'hC, 32'h3);
    chk(32'(cmd_reg_r), 32'h0, "command write in d3");
    xfer(PTD_CFG_WR, 32'(PTD_OFF_PM), 1'b1, 4'hE, 32'h1);
    chk(32'(pwr_view), 32'h19, "reserved code");
    xfer(PTD_CFG_RD, 32'(PTD_OFF_PM), 1'b1, 4'hE, 32'h0);
    chk(got_data, 32'h1, "code readback");
    xfer(PTD_CFG_WR, 32'(PTD_OFF_PM), 1'b1, 4'hE, 32'h0);
    chk(32'(pwr_view), 32'h06, "back to d0");
    xfer(PTD_CFG_RD, 32'(PTD_OFF_PM), 1'b1, 4'hE, 32'h0);
    chk(got_data, 32'h0, "d0 readback");
  endtask : t_power
  task automatic complete_run();
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_config();
    t_window();
    t_power();
    complete_run();
  end
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule : tb_top
